// ### hw/mvph_defines.svh
// register offsets, field positions, reset values and counts for the vlan/pause/hash block
`ifndef MVPH_DEFINES_SVH
`define MVPH_DEFINES_SVH
// ----------------------------------------------------------------------------
// register byte offsets (apb, one aligned word each)
// ----------------------------------------------------------------------------
`define MVPH_ADDR_W        8
`define MVPH_OFS_TPID      8'h00
`define MVPH_OFS_TCI       8'h04
`define MVPH_OFS_PTR       8'h08
`define MVPH_OFS_IHASH     8'h0C
`define MVPH_OFS_GHASH     8'h1C
`define MVPH_OFS_LSRC      8'h2C
`define MVPH_OFS_CTRL      8'h30
`define MVPH_HASH_REGS     4
`define MVPH_HASH_STRIDE   8'h04
// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define MVPH_FLD_W         16
`define MVPH_FLD_ZERO      16'h0000
`define MVPH_TPID_RST      16'h8100
`define MVPH_TCI_RST       16'h0000
`define MVPH_PTR_RST       16'h0000
`define MVPH_HASH_RST      16'h0000
`define MVPH_CTRL_IAH_BIT  0
`define MVPH_CTRL_GAH_BIT  1
`define MVPH_CTRL_VLN_LO   2
`define MVPH_CTRL_VLN_HI   3
`define MVPH_CTRL_W        4
`define MVPH_CTRL_RST      4'h0
// ----------------------------------------------------------------------------
// frame byte positions and pause quantum
// ----------------------------------------------------------------------------
`define MVPH_BYTE_DA_LAST  4'h6
`define MVPH_BYTE_SA_HI0   4'h7
`define MVPH_BYTE_SA_HI1   4'h8
`define MVPH_BYTE_TPID0    4'hD
`define MVPH_BYTE_TPID1    4'hE
`define MVPH_BYTE_MAX      4'hF
`define MVPH_QUANTUM_BITS  512
`define MVPH_QUANTUM_LAST  9'h1FF
`endif

// ### hw/mvph_pkg.sv
// types shared by the vlan/pause/hash register block
package mvph_pkg;
  // transmit vlan handling selected by software
  typedef enum logic [1:0] {
    MVPH_VLAN_OFF,
    MVPH_VLAN_INCLUDE,
    MVPH_VLAN_REPLACE,
    MVPH_VLAN_RSVD
  } mvph_vlan_mode_t;

  // one received byte from the frame datapath
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       err;
    logic [7:0] data;
  } mvph_rx_beat_t;

  // tag values handed to the transmit datapath
  typedef struct packed {
    logic        insert;
    logic        replace;
    logic [15:0] tpid;
    logic [15:0] tci;
  } mvph_tx_vlan_t;
endpackage

// ### hw/mvph_regs.sv
// vlan tag, pause timer, address hash and last source address registers behind apb
// How it works
// - compare rx bytes 13-14 with stored tpid
// - tx uses stored tpid in include/replace modes
// - stored tci drives tx tag in those modes
// - pause register sets pause time, fills frames
// - one pause count equals 512 bit times
// - pause field in low half, upper reserved
// - four individual hash regs feed unicast filter
// - four group hash regs feed group filter
// - individual hash regs hold 16 low bits
// - group hash regs hold 16 low bits
// - capture source address high of good frame
// - good means forwarded to memory access layer
`include "mvph_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module mvph_regs (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`MVPH_ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire mvph_pkg::mvph_rx_beat_t     rx_beat,
  output logic                             rx_vlan_tagged,
  output logic                             rx_forward,
  output mvph_pkg::mvph_tx_vlan_t          tx_vlan,
  output logic      [15:0]                 tx_pause_quanta,
  input  wire logic                        pause_start,
  input  wire logic                        bit_tick,
  output logic                             pause_active
);

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  logic [`MVPH_FLD_W-1:0] tpid_q;
  logic [`MVPH_FLD_W-1:0] tci_q;
  logic [`MVPH_FLD_W-1:0] ptr_q;
  logic [`MVPH_FLD_W-1:0] indiv_q [`MVPH_HASH_REGS];
  logic [`MVPH_FLD_W-1:0] group_q [`MVPH_HASH_REGS];
  logic [`MVPH_FLD_W-1:0] last_sa_q;
  logic [`MVPH_CTRL_W-1:0] ctrl_q;
  logic [31:0]            prdata_q;
  logic                   pslverr_q;
  logic [31:0]            rd_d;
  logic                   hit_d;
  logic                   wr_en;
  logic                   setup;

  mvph_pkg::mvph_vlan_mode_t vlan_mode;
  logic                      iah_en;
  logic                      gah_en;

  assign vlan_mode = mvph_pkg::mvph_vlan_mode_t'(ctrl_q[`MVPH_CTRL_VLN_HI:`MVPH_CTRL_VLN_LO]);
  assign iah_en    = ctrl_q[`MVPH_CTRL_IAH_BIT];
  assign gah_en    = ctrl_q[`MVPH_CTRL_GAH_BIT];

  // --------------------------------------------------------------------------
  // apb slave: zero wait states, read data latched in the setup cycle
  // --------------------------------------------------------------------------
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & hit_d;
  assign pready = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // read mux and decode; reserved upper halves always read zero
  always_comb begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    if (paddr == `MVPH_OFS_TPID) begin
      rd_d = {`MVPH_FLD_ZERO, tpid_q};
    end else if (paddr == `MVPH_OFS_TCI) begin
      rd_d = {`MVPH_FLD_ZERO, tci_q};
    end else if (paddr == `MVPH_OFS_PTR) begin
      rd_d = {`MVPH_FLD_ZERO, ptr_q};
    end else if (paddr == `MVPH_OFS_LSRC) begin
      rd_d = {`MVPH_FLD_ZERO, last_sa_q};
    end else if (paddr == `MVPH_OFS_CTRL) begin
      rd_d = {28'h000_0000, ctrl_q};
    end else begin
      hit_d = 1'b0;
      for (int i = 0; i < `MVPH_HASH_REGS; i++) begin
        if (paddr == `MVPH_OFS_IHASH + 8'(i) * `MVPH_HASH_STRIDE) begin
          rd_d  = {`MVPH_FLD_ZERO, indiv_q[i]};
          hit_d = 1'b1;
        end
        if (paddr == `MVPH_OFS_GHASH + 8'(i) * `MVPH_HASH_STRIDE) begin
          rd_d  = {`MVPH_FLD_ZERO, group_q[i]};
          hit_d = 1'b1;
        end
      end
    end
  end

  // read data and error answer are ready by the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr_q <= ~hit_d;
    end
  end

  // software-written registers; the upper halves are not stored at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tpid_q <= `MVPH_TPID_RST;
      tci_q  <= `MVPH_TCI_RST;
      ptr_q  <= `MVPH_PTR_RST;
      ctrl_q <= `MVPH_CTRL_RST;
    end else if (wr_en) begin
      if (paddr == `MVPH_OFS_TPID) begin
        tpid_q <= pwdata[15:0];
      end else if (paddr == `MVPH_OFS_TCI) begin
        tci_q <= pwdata[15:0];
      end else if (paddr == `MVPH_OFS_PTR) begin
        ptr_q <= pwdata[15:0];
      end else if (paddr == `MVPH_OFS_CTRL) begin
        ctrl_q <= pwdata[`MVPH_CTRL_W-1:0];
      end
    end
  end

  // hash table words, one generate entry per register pair
  for (genvar g = 0; g < `MVPH_HASH_REGS; g++) begin : g_hash
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        indiv_q[g] <= `MVPH_HASH_RST;
        group_q[g] <= `MVPH_HASH_RST;
      end else if (wr_en) begin
        if (paddr == `MVPH_OFS_IHASH + 8'(g) * `MVPH_HASH_STRIDE) begin
          indiv_q[g] <= pwdata[15:0];
        end
        if (paddr == `MVPH_OFS_GHASH + 8'(g) * `MVPH_HASH_STRIDE) begin
          group_q[g] <= pwdata[15:0];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // transmit tag and pause values
  // --------------------------------------------------------------------------
  logic tx_ins_q;
  logic tx_rep_q;

  // tpid and tci are offered in every mode; only the insert/replace flags follow the chosen mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ins_q <= 1'b0;
      tx_rep_q <= 1'b0;
    end else begin
      tx_ins_q <= (vlan_mode == mvph_pkg::MVPH_VLAN_INCLUDE);
      tx_rep_q <= (vlan_mode == mvph_pkg::MVPH_VLAN_REPLACE);
    end
  end

  assign tx_vlan.insert   = tx_ins_q;
  assign tx_vlan.replace  = tx_rep_q;
  assign tx_vlan.tpid     = tpid_q;
  assign tx_vlan.tci      = tci_q;
  assign tx_pause_quanta  = ptr_q;

  // --------------------------------------------------------------------------
  // pause timer: ptr quanta of 512 bit ticks each
  // --------------------------------------------------------------------------
  logic [15:0] quanta_q;
  logic [8:0]  bits_q;

  // a new pause request restarts the count; a zero value ends the pause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quanta_q <= `MVPH_FLD_ZERO;
      bits_q   <= 9'h000;
    end else if (pause_start) begin
      quanta_q <= ptr_q;
      bits_q   <= 9'h000;
    end else if (bit_tick && quanta_q != `MVPH_FLD_ZERO) begin
      if (bits_q == `MVPH_QUANTUM_LAST) begin
        bits_q   <= 9'h000;
        quanta_q <= quanta_q - 16'h0001;
      end else begin
        bits_q <= bits_q + 9'h001;
      end
    end
  end

  assign pause_active = (quanta_q != `MVPH_FLD_ZERO);

  // --------------------------------------------------------------------------
  // receive: byte position, address capture, tag check, hash filter
  // --------------------------------------------------------------------------
  logic [3:0]  idx_q;
  logic [3:0]  cur;
  logic [47:0] da_q;
  logic [15:0] sa_hi_q;
  logic [7:0]  tpid_b0_q;
  logic        tagged_q;
  logic [5:0]  hash;
  logic        hash_bit;
  logic        accept;
  logic        fwd_q;
  logic        frame_end;

  // byte number within the frame, saturating past the tag field
  assign cur = rx_beat.sof ? 4'h1 :
               (idx_q == `MVPH_BYTE_MAX) ? idx_q : idx_q + 4'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q     <= 4'h0;
      da_q      <= 48'h0000_0000_0000;
      sa_hi_q   <= `MVPH_FLD_ZERO;
      tpid_b0_q <= 8'h00;
    end else if (rx_beat.valid) begin
      idx_q <= cur;
      if (cur <= `MVPH_BYTE_DA_LAST) begin
        da_q <= {da_q[39:0], rx_beat.data};
      end
      if (cur == `MVPH_BYTE_SA_HI0) begin
        sa_hi_q[15:8] <= rx_beat.data;
      end
      if (cur == `MVPH_BYTE_SA_HI1) begin
        sa_hi_q[7:0] <= rx_beat.data;
      end
      if (cur == `MVPH_BYTE_TPID0) begin
        tpid_b0_q <= rx_beat.data;
      end
    end
  end

  // tag flag decided on byte 14, cleared at the next frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tagged_q <= 1'b0;
    end else if (rx_beat.valid && rx_beat.sof) begin
      tagged_q <= 1'b0;
    end else if (rx_beat.valid && cur == `MVPH_BYTE_TPID1) begin
      tagged_q <= ({tpid_b0_q, rx_beat.data} == tpid_q);
    end
  end

  assign rx_vlan_tagged = tagged_q;

  // six-bit index folded from the destination address by xor
  always_comb begin
    hash = 6'h00;
    for (int k = 0; k < 8; k++) begin
      hash = hash ^ da_q[k*6 +: 6];
    end
  end

  // first destination byte lsb marks a group address
  always_comb begin
    if (da_q[40]) begin
      hash_bit = group_q[hash[5:4]][hash[3:0]];
      accept   = ~gah_en | hash_bit;
    end else begin
      hash_bit = indiv_q[hash[5:4]][hash[3:0]];
      accept   = ~iah_en | hash_bit;
    end
  end

  // frames that end before byte 8, the last source address high byte, skip the filter, except a one-beat sof and eof frame after a frame of 7 or more bytes
  assign frame_end = rx_beat.valid & rx_beat.eof & ~rx_beat.err &
                     (idx_q >= `MVPH_BYTE_SA_HI0);

  // one-cycle forward pulse; only forwarded frames refresh the source address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_q     <= 1'b0;
      last_sa_q <= `MVPH_FLD_ZERO;
    end else begin
      fwd_q <= frame_end & accept;
      if (frame_end && accept) begin
        last_sa_q <= sa_hi_q;
      end
    end
  end

  assign rx_forward = fwd_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  property p_tag_detect;
    @(posedge pclk) disable iff (!presetn)
      (rx_beat.valid && !rx_beat.sof && cur == `MVPH_BYTE_TPID1 &&
       {tpid_b0_q, rx_beat.data} == tpid_q) |=> rx_vlan_tagged;
  endproperty
  a_tag_detect: assert property (p_tag_detect) else $error("tag not flagged");

  property p_tx_insert;
    @(posedge pclk) disable iff (!presetn)
      (vlan_mode == mvph_pkg::MVPH_VLAN_INCLUDE) ##1
      (vlan_mode == mvph_pkg::MVPH_VLAN_INCLUDE) |-> tx_vlan.insert && !tx_vlan.replace;
  endproperty
  a_tx_insert: assert property (p_tx_insert) else $error("insert mode not offered");

  property p_tci_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `MVPH_OFS_TCI) |=> tx_vlan.tci == $past(pwdata[15:0]);
  endproperty
  a_tci_write: assert property (p_tci_write) else $error("tci not updated");

  property p_pause_len;
    @(posedge pclk) disable iff (!presetn)
      (pause_start && ptr_q != `MVPH_FLD_ZERO) |=> pause_active && quanta_q == $past(ptr_q);
  endproperty
  a_pause_len: assert property (p_pause_len) else $error("pause not loaded");

  property p_quantum;
    @(posedge pclk) disable iff (!presetn)
      (bit_tick && !pause_start && bits_q == `MVPH_QUANTUM_LAST && pause_active)
      |=> quanta_q == $past(quanta_q) - 16'h0001;
  endproperty
  a_quantum: assert property (p_quantum) else $error("quantum not 512 ticks");

  property p_ptr_rsvd;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `MVPH_OFS_PTR)
      |=> prdata[31:16] == `MVPH_FLD_ZERO && prdata[15:0] == ptr_q;
  endproperty
  a_ptr_rsvd: assert property (p_ptr_rsvd) else $error("pause read wrong");

  property p_ihash_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `MVPH_OFS_IHASH)
      |=> prdata == {`MVPH_FLD_ZERO, indiv_q[0]};
  endproperty
  a_ihash_read: assert property (p_ihash_read) else $error("hash read wrong");

  property p_ghash_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `MVPH_OFS_GHASH)
      |=> prdata == {`MVPH_FLD_ZERO, group_q[0]};
  endproperty
  a_ghash_read: assert property (p_ghash_read) else $error("group read wrong");

  property p_ia_accept;
    @(posedge pclk) disable iff (!presetn)
      (frame_end && !da_q[40] && hash_bit) |=> rx_forward;
  endproperty
  a_ia_accept: assert property (p_ia_accept) else $error("unicast hit dropped");

  property p_ga_accept;
    @(posedge pclk) disable iff (!presetn)
      (frame_end && da_q[40] && hash_bit) |=> rx_forward;
  endproperty
  a_ga_accept: assert property (p_ga_accept) else $error("group hit dropped");

  property p_last_sa;
    @(posedge pclk) disable iff (!presetn)
      rx_forward |-> last_sa_q == $past(sa_hi_q);
  endproperty
  a_last_sa: assert property (p_last_sa) else $error("source address not captured");

  property p_last_sa_hold;
    @(posedge pclk) disable iff (!presetn)
      !rx_forward |-> $stable(last_sa_q);
  endproperty
  a_last_sa_hold: assert property (p_last_sa_hold) else $error("source changed w/o forward");

  property p_drop;
    @(posedge pclk) disable iff (!presetn)
      (frame_end && !hash_bit && (da_q[40] ? gah_en : iah_en)) |=> !rx_forward;
  endproperty
  a_drop: assert property (p_drop) else $error("hash miss forwarded");

  c_tagged: cover property (@(posedge pclk) disable iff (!presetn) $rose(rx_vlan_tagged));
  c_forward: cover property (@(posedge pclk) disable iff (!presetn) rx_forward);
  c_pause_end: cover property (@(posedge pclk) disable iff (!presetn) $fell(pause_active));
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr && penable);

endmodule

`default_nettype wire

// ### testbench/mvph_regs_tb.sv
// self-checking bench for the vlan/pause/hash register block
`include "mvph_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module mvph_regs_tb;
  logic                    pclk, presetn, psel, penable, pwrite, pause_start;
  logic                    pready, pslverr, rx_vlan_tagged, rx_forward, pause_active;
  logic                    bit_tick;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic [15:0]             tx_pause_quanta;
  logic                    er;
  mvph_pkg::mvph_rx_beat_t rx_beat;
  mvph_pkg::mvph_tx_vlan_t tx_vlan;
  int                      n_errors = 0;
  int                      num_checks = 0;
  int                      fwd_cnt = 0;
  // byte addresses chosen by the designer
  localparam logic [7:0] A_TPID = 8'h00, A_TCI = 8'h04, A_PAUSE = 8'h08, A_IHASH = 8'h0C;
  localparam logic [7:0] A_GHASH = 8'h1C, A_LSRC = 8'h2C, A_CTRL = 8'h30, A_NONE = 8'h34;

  mvph_regs i_mvph_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_beat(rx_beat), .rx_vlan_tagged(rx_vlan_tagged),
    .rx_forward(rx_forward), .tx_vlan(tx_vlan), .tx_pause_quanta(tx_pause_quanta),
    .pause_start(pause_start), .bit_tick(bit_tick), .pause_active(pause_active));
  mvph_rx_model i_mvph_rx_model (.pclk(pclk), .rx_beat(rx_beat), .bit_tick(bit_tick));

  // ----------------------------------------------------------------------
  // clock, forward pulse counter, watchdog
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (rx_forward === 1'b1) fwd_cnt <= fwd_cnt + 1;
  // the whole run needs about 2400 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      $display("CHECK FAILED %0t %s", $time, msg);
      n_errors++;
    end
  endtask
  // one apb transfer; waits for pready under a bound, an edge separates transfers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // send a frame, then compare the forward count and captured source address
  task automatic frame(input logic [127:0] f, input logic bad, input int fw, input logic [15:0] sa);
    int c0;
    c0 = fwd_cnt;
    i_mvph_rx_model.send_frame(f, bad);
    repeat (2) @(posedge pclk);
    chk(fwd_cnt == c0 + fw, "forward pulse count");
    apb(1'b0, A_LSRC, 32'h0);
    chk(rd === {16'h0000, sa}, "last source address");
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, A_TPID, 32'h0);
    chk(rd === {16'h0000, `MVPH_TPID_RST}, "tpid reset");
    for (int k = 1; k < 12; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(rd === 32'h0000_0000 && er === 1'b0, "reset value");
    end
    chk(tx_vlan.insert === 1'b0 && tx_vlan.replace === 1'b0, "tx tag flags at reset");
  endtask
  // upper half ignored, read-only and unmapped places
  task automatic t_regs();
    for (int k = 1; k < 11; k++) begin
      apb(1'b1, 8'(k * 4), {16'hFFFF, 16'(k * 16'h1111)});
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(rd === {16'h0000, 16'(k * 16'h1111)}, "field readback");
    end
    chk(tx_pause_quanta === 16'h2222, "pause quanta output");
    apb(1'b1, A_LSRC, 32'h0000_ABCD);
    chk(rd === 32'h0 && er === 1'b0, "read-only write");
    apb(1'b1, A_NONE, 32'h0000_0005);
    chk(er === 1'b1, "unmapped write error");
    apb(1'b0, A_NONE, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read error");
    apb(1'b0, A_LSRC, 32'h0);
    chk(rd === 32'h0, "read-only unchanged");
    apb(1'b1, A_TPID, 32'h0000_8100);
  endtask
  // every transmit tag mode
  task automatic t_txvlan();
    apb(1'b1, A_TCI, 32'h0000_5A3C);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, A_CTRL, 32'(m << 2));
      @(posedge pclk);
      #1;
      chk(tx_vlan.insert === (m == 1) && tx_vlan.replace === (m == 2), "tx mode");
      chk(tx_vlan.tpid === 16'h8100 && tx_vlan.tci === 16'h5A3C, "tx tag");
    end
    apb(1'b1, A_CTRL, 32'h0);
  endtask
  // tag detection, good and bad frames
  task automatic t_rx();
    frame({48'h0, 16'h1234, 32'h0, 16'h8100, 16'h0}, 1'b0, 1, 16'h1234);
    chk(rx_vlan_tagged === 1'b1, "tag seen");
    frame({48'h0, 16'hBEEF, 32'h0, 16'h8101, 16'h0}, 1'b1, 0, 16'h1234);
    chk(rx_vlan_tagged === 1'b0, "no tag");
  endtask
  // da all zero hashes to index 0; da byte1 = 01 hashes to index 16
  task automatic t_hash();
    for (int k = 0; k < 4; k++) apb(1'b1, 8'(A_IHASH + 4 * k), 32'h0);
    for (int k = 0; k < 4; k++) apb(1'b1, 8'(A_GHASH + 4 * k), 32'h0);
    apb(1'b1, A_CTRL, 32'h0000_0001);
    frame({48'h0, 16'h1111, 64'h0}, 1'b0, 0, 16'h1234);
    apb(1'b1, A_IHASH, 32'h0000_0001);
    frame({48'h0, 16'h1111, 64'h0}, 1'b0, 1, 16'h1111);
    apb(1'b1, A_CTRL, 32'h0000_0002);
    frame({48'h0100_0000_0000, 16'h2222, 64'h0}, 1'b0, 0, 16'h1111);
    apb(1'b1, A_GHASH + 8'h04, 32'h0000_0001);
    frame({48'h0100_0000_0000, 16'h2222, 64'h0}, 1'b0, 1, 16'h2222);
    apb(1'b1, A_CTRL, 32'h0);
  endtask
  // two quanta of 512 bit times, then a zero field
  task automatic t_pause(input logic [15:0] q);
    apb(1'b1, A_PAUSE, {16'h0000, q});
    // the write lands on the edge the task returns at; look once it has settled
    #1;
    chk(tx_pause_quanta === q, "pause quanta");
    @(posedge pclk);
    pause_start <= 1'b1;
    @(posedge pclk);
    pause_start <= 1'b0;
    #1;
    chk(pause_active === (q != 16'h0), "pause begins");
    if (q != 16'h0) begin
      i_mvph_rx_model.ticks(`MVPH_QUANTUM_BITS * q - 1);
      #1;
      chk(pause_active === 1'b1, "pause holds");
      i_mvph_rx_model.ticks(1);
      @(posedge pclk);
      #1;
      chk(pause_active === 1'b0, "pause ends");
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pause_start = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_txvlan();
    t_rx();
    t_hash();
    t_pause(16'h0002);
    t_pause(16'h0000);
    summarize();
  end
endmodule
`default_nettype wire

// ### testbench/mvph_rx_model.sv
// frame datapath and line bit-time source facing the vlan/pause/hash registers
`timescale 1ns/10ps
`default_nettype none

module mvph_rx_model (
  input  wire logic                   pclk,
  output var  mvph_pkg::mvph_rx_beat_t rx_beat,
  output logic                        bit_tick
);
  // ----------------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------------
  initial begin
    rx_beat  = '0;
    bit_tick = 1'b0;
  end

  // sixteen bytes, one per cycle, byte 1 in the top bits of frm
  task automatic send_frame(input logic [127:0] frm, input logic bad);
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      rx_beat.valid <= 1'b1;
      rx_beat.sof   <= (i == 0);
      rx_beat.eof   <= (i == 15);
      rx_beat.err   <= bad && (i == 15);
      rx_beat.data  <= frm[127-8*i -: 8];
    end
    @(posedge pclk);
    rx_beat.valid <= 1'b0;
    rx_beat.sof   <= 1'b0;
    rx_beat.eof   <= 1'b0;
    rx_beat.err   <= 1'b0;
    // idle data is inverted so a stale byte can never look valid
    rx_beat.data  <= ~rx_beat.data;
  endtask

  // one bit-time pulse every other cycle
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      bit_tick <= 1'b1;
      @(posedge pclk);
      bit_tick <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire
